// ==== hdl/rxcfg_pkg.sv ====
// Constants and carrier types for the receive DMA channel configuration memory.
// Assumes one 100 MHz system clock and a plain register port from software.
// Overview of operation
// - Word 0 holds current buffer address
// - Word 1 low half: current descriptor offset
// - Word 1 high half: starting descriptor offset
// - Word 2 bit 0 enables channel
// - Word 2 bits 1-2 buffer policy, 11 illegal
// - Threshold bits 7-9: packet end or N buffers
// - Bit 15 flags first buffer of packet
// - Bits 16-28 byte count, max 1FFC
// - Bits 29-31 count filled buffers
// - Channel index selects one of 256
// - Word select picks half; only 100 writable
// - Read command fetches word, busy until ready
// - Write command stores data, busy until done
// - Busy flag read-only, high during access
// - Data register carries written and read values
package rxcfg_pkg;
   localparam int          RXCFG_CHANNELS   = 256;
   localparam int          RXCFG_CH_W       = 8;
   localparam int          RXCFG_ADDR_W     = 12;
   localparam logic [11:0] RXCFG_SELECT_OFF = 12'h770;
   localparam logic [11:0] RXCFG_DATA_OFF   = 12'h774;
   localparam logic [15:0] RXCFG_SELECT_RST = 16'h0000;
   localparam logic [15:0] RXCFG_DATA_RST   = 16'h0000;
   localparam int          RXCFG_SEL_CH_LSB = 0;
   localparam int          RXCFG_SEL_WS_LSB = 8;
   localparam int          RXCFG_SEL_RW_BIT = 14;
   localparam int          RXCFG_SEL_BSY_BIT = 15;
   localparam logic [2:0]  RXCFG_WS_HOST_WR = 3'h4;
   localparam logic [2:0]  RXCFG_WS_LAST    = 3'h5;
   localparam logic [15:0] RXCFG_HOST_WR_MASK = 16'h0387;
   localparam logic [12:0] RXCFG_BYTE_MAX   = 13'h1FFC;
   localparam logic [2:0]  RXCFG_THR_PACKET = 3'h0;
   localparam logic [1:0]  RXCFG_POL_LARGE  = 2'h0;
   localparam logic [1:0]  RXCFG_POL_SMALL  = 2'h1;
   localparam logic [1:0]  RXCFG_POL_MIXED  = 2'h2;

   typedef struct packed {
      logic [31:0] buf_addr;      // word 0
      logic [15:0] start_desc;    // word 1 high
      logic [15:0] cur_desc;      // word 1 low
      logic [2:0]  buf_count;     // word 2 bits 31:29
      logic [12:0] byte_count;    // word 2 bits 28:16
      logic        first_buffer_flag;
      logic [4:0]  rsvd_hi;
      logic [2:0]  threshold;
      logic [3:0]  rsvd_lo;
      logic [1:0]  buf_policy;
      logic        channel_enable_flag;
   } rxcfg_entry_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } rxcfg_bus_t;

   typedef struct packed {
      logic [7:0]  ch;
      logic        wr;
      rxcfg_entry_t wdata;
   } rxcfg_port_t;

   typedef enum logic [1:0] {
      RXCFG_IDLE  = 2'b00,
      RXCFG_FETCH = 2'b01,
      RXCFG_STORE = 2'b10
   } rxcfg_state_t;
endpackage : rxcfg_pkg

// ==== hdl/rxcfg_entry_ram.sv ====
// Flip-flop storage of the 256 three-word channel entries, two ports.
// Assumes the host port and the DMA port never write the same entry at once.
`timescale 1ns/1ps
`default_nettype none
module rxcfg_entry_ram
   import rxcfg_pkg::*;
(
   input  wire logic         sys_clk,   // System clock
   input  wire logic         reset,     // Async reset, high
   input  wire rxcfg_port_t  host_p,    // Host side access
   input  wire rxcfg_port_t  dma_p,     // DMA side access
   output var rxcfg_entry_t   host_q,    // Host entry, registered
   output var rxcfg_entry_t   dma_q      // DMA entry, combinational
);
   rxcfg_entry_t mem_q [RXCFG_CHANNELS];

   // DMA writes second so its update wins; host writes the whole entry, non-host fields from its host_q copy
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < RXCFG_CHANNELS; i++) begin
            mem_q[i] <= '0;
         end
         host_q <= '0;
      end else begin
         host_q <= mem_q[host_p.ch];
         if (host_p.wr) begin
            mem_q[host_p.ch] <= rxcfg_entry_t'(host_p.wdata);
         end
         if (dma_p.wr) begin
            mem_q[dma_p.ch] <= rxcfg_entry_t'(dma_p.wdata);
         end
      end
   end

   assign dma_q = mem_q[dma_p.ch];
endmodule : rxcfg_entry_ram
`default_nettype wire

// ==== hdl/rxcfg_top.sv ====
// Receive DMA channel configuration memory with indirect select/data access.
// Assumes a plain register port; DMA engine drives the per-channel update port.
`timescale 1ns/1ps
`default_nettype none
module rxcfg_top
   import rxcfg_pkg::*;
(
   input  wire logic        sys_clk,          // System clock, 100 MHz
   input  wire logic        reset,            // Async reset, high
   input  wire logic [11:0] reg_addr,         // Register byte address
   input  wire logic [15:0] reg_wdata,        // Register write data
   input  wire logic        reg_wr,           // Write strobe
   input  wire logic        reg_rd,           // Read strobe
   output logic      [15:0] reg_rdata,        // Read data, next cycle
   input  wire logic [7:0]  dma_channel,      // DMA selected channel
   input  wire logic        dma_wr,           // DMA entry update strobe
   input  wire logic [31:0] dma_buf_addr,     // New buffer address
   input  wire logic [15:0] dma_cur_desc,     // New current descriptor
   input  wire logic [15:0] dma_start_desc,   // New start descriptor
   input  wire logic        dma_first_buf,    // New first buffer flag
   input  wire logic [12:0] dma_byte_count,   // New byte count
   input  wire logic [2:0]  dma_buf_count,    // New filled buffer count
   input  wire logic        dma_pkt_done,     // Packet completed this update
   output logic             cfg_enable,       // Channel enabled
   output logic      [1:0]  cfg_policy,       // Buffer policy
   output logic             cfg_use_small,    // Next buffer is small
   output logic      [2:0]  cfg_threshold,    // Done queue threshold
   output logic             cfg_post_done     // Post start descriptor now
);
   typedef struct packed {
      logic [15:0]  select;
      logic [15:0]  data;
      logic [15:0]  rdata;
      rxcfg_state_t st;
      logic         cfg_enable;
      logic [1:0]   cfg_policy;
      logic         cfg_use_small;
      logic [2:0]   cfg_threshold;
      logic         cfg_post_done;
   } rxcfg_regs_t;

   rxcfg_regs_t  r_q, r_d;
   rxcfg_port_t  host_p, dma_p;
   rxcfg_entry_t host_e, dma_e, dma_new;
   logic         sel_take;
   logic [2:0]   ws;
   logic [7:0]   ch;

   assign ws = r_q.select[RXCFG_SEL_WS_LSB +: 3];
   assign ch = r_q.select[RXCFG_SEL_CH_LSB +: RXCFG_CH_W];
   // Commands are only taken while idle; busy drops anything else
   assign sel_take = reg_wr && reg_addr == RXCFG_SELECT_OFF && r_q.st == RXCFG_IDLE;

   rxcfg_entry_ram u_ram (
      .sys_clk (sys_clk),
      .reset   (reset),
      .host_p  (host_p),
      .dma_p   (dma_p),
      .host_q  (host_e),
      .dma_q   (dma_e)
   );

   // DMA update keeps host-owned bits, replaces DMA-owned fields
   always_comb begin
      dma_new                    = dma_e;
      dma_new.buf_addr           = dma_buf_addr;
      dma_new.cur_desc           = dma_cur_desc;
      dma_new.start_desc         = dma_start_desc;
      dma_new.first_buffer_flag  = dma_first_buf;
      dma_new.byte_count         = (dma_byte_count > RXCFG_BYTE_MAX) ?
                                   RXCFG_BYTE_MAX : dma_byte_count;
      dma_new.buf_count          = dma_buf_count;
      dma_p.ch    = dma_channel;
      dma_p.wr    = dma_wr;
      dma_p.wdata = dma_new;
   end

   // Host store only reaches the low half of word 2
   always_comb begin
      rxcfg_entry_t e;
      e = host_e;
      e.channel_enable_flag = r_q.data[0];
      e.buf_policy          = r_q.data[2:1];
      e.threshold           = r_q.data[9:7];
      // Aim the registered read at the new channel as the command is taken
      host_p.ch    = sel_take ? reg_wdata[RXCFG_SEL_CH_LSB +: RXCFG_CH_W] : ch;
      host_p.wr    = (r_q.st == RXCFG_STORE) && (ws == RXCFG_WS_HOST_WR);
      host_p.wdata = e;
   end

   always_comb begin
      logic [15:0] w2lo;
      logic [15:0] w2hi;
      w2lo = {host_e.first_buffer_flag, host_e.rsvd_hi, host_e.threshold,
              host_e.rsvd_lo, host_e.buf_policy, host_e.channel_enable_flag};
      w2hi = {host_e.buf_count, host_e.byte_count};
      r_d  = r_q;
      r_d.rdata = '0;
      r_d.cfg_post_done = 1'b0;
      case (r_q.st)
         RXCFG_FETCH: begin
            case (ws)
               3'h0:    r_d.data = host_e.buf_addr[15:0];
               3'h1:    r_d.data = host_e.buf_addr[31:16];
               3'h2:    r_d.data = host_e.cur_desc;
               3'h3:    r_d.data = host_e.start_desc;
               3'h4:    r_d.data = w2lo;
               3'h5:    r_d.data = w2hi;
               default: r_d.data = r_q.data;
            endcase
            r_d.select[RXCFG_SEL_BSY_BIT] = 1'b0;
            r_d.st = RXCFG_IDLE;
         end
         RXCFG_STORE: begin
            r_d.select[RXCFG_SEL_BSY_BIT] = 1'b0;
            r_d.st = RXCFG_IDLE;
         end
         default: begin
            r_d.st = RXCFG_IDLE;
         end
      endcase
      // Busy bit is ignored on writes; a new command while busy is dropped
      if (sel_take) begin
         r_d.select = {1'b1, reg_wdata[RXCFG_SEL_RW_BIT], 3'h0, reg_wdata[10:0]};
         r_d.st     = reg_wdata[RXCFG_SEL_RW_BIT] ? RXCFG_FETCH : RXCFG_STORE;
         if (reg_wdata[10:8] > RXCFG_WS_LAST) begin
            r_d.st = RXCFG_IDLE;
            r_d.select[RXCFG_SEL_BSY_BIT] = 1'b0;
         end
      end else if (reg_wr && reg_addr == RXCFG_DATA_OFF && r_q.st == RXCFG_IDLE) begin
         r_d.data = reg_wdata;
      end
      if (reg_rd) begin
         if (reg_addr == RXCFG_SELECT_OFF) begin
            r_d.rdata = r_q.select;
         end else if (reg_addr == RXCFG_DATA_OFF) begin
            r_d.rdata = r_q.data;
         end else begin
            r_d.rdata = '0;
         end
      end
      // Live view of the entry the DMA is working on
      r_d.cfg_enable    = dma_e.channel_enable_flag;
      r_d.cfg_policy    = dma_e.buf_policy;
      r_d.cfg_threshold = dma_e.threshold;
      r_d.cfg_use_small = (dma_e.buf_policy == RXCFG_POL_SMALL) ||
                          (dma_e.buf_policy == RXCFG_POL_MIXED &&
                           dma_e.first_buffer_flag);
      if (dma_wr && dma_e.channel_enable_flag) begin
         if (dma_e.threshold == RXCFG_THR_PACKET) begin
            r_d.cfg_post_done = dma_pkt_done;
         end else begin
            r_d.cfg_post_done = dma_pkt_done ||
                                (dma_buf_count >= dma_e.threshold);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r_q        <= '0;
         r_q.select <= RXCFG_SELECT_RST;
         r_q.data   <= RXCFG_DATA_RST;
         r_q.st     <= RXCFG_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign reg_rdata     = r_q.rdata;
   assign cfg_enable    = r_q.cfg_enable;
   assign cfg_policy    = r_q.cfg_policy;
   assign cfg_use_small = r_q.cfg_use_small;
   assign cfg_threshold = r_q.cfg_threshold;
   assign cfg_post_done = r_q.cfg_post_done;
endmodule : rxcfg_top
`default_nettype wire

// ==== test/rxcfg_chk.sv ====
// Port-level assertions for the receive DMA configuration memory.
// Assumes the host polls busy, so one indirect command is in flight at once.
`timescale 1ns/1ps
`default_nettype none
module rxcfg_chk
   import rxcfg_pkg::*;
(
   input wire logic        sys_clk,       // Clock
   input wire logic        reset,         // Async reset, high
   input wire logic [11:0] reg_addr,      // Register address
   input wire logic [15:0] reg_wdata,     // Register write data
   input wire logic        reg_wr,        // Write strobe
   input wire logic        reg_rd,        // Read strobe
   input wire logic [15:0] reg_rdata,     // Read data
   input wire logic        dma_wr,        // DMA update strobe
   input wire logic        cfg_enable,    // Channel enabled
   input wire logic [1:0]  cfg_policy,    // Buffer policy
   input wire logic        cfg_use_small, // Small buffer next
   input wire logic        cfg_post_done  // Done queue post
);
   wire sel_wr = reg_wr && reg_addr == RXCFG_SELECT_OFF;
   wire sel_rd = reg_rd && reg_addr == RXCFG_SELECT_OFF;
   wire map_rd = sel_rd || reg_addr == RXCFG_DATA_OFF;
   wire cmd_rd = sel_wr && reg_wdata[14] && reg_wdata[10:8] <= RXCFG_WS_LAST;
   wire cmd_wr = sel_wr && !reg_wdata[14] && reg_wdata[10:8] == RXCFG_WS_HOST_WR;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (reg_rd && !map_rd |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_busy_on_read: assert property (cmd_rd ##1 sel_rd |=> reg_rdata[15])
      else $error("busy low right after read command");
   a_busy_read_ends: assert property (cmd_rd ##[2:3] sel_rd |=> !reg_rdata[15])
      else $error("busy still high after fetch");
   a_busy_on_write: assert property (cmd_wr ##1 sel_rd |=> reg_rdata[15])
      else $error("busy low right after write command");
   a_illegal_ws: assert property (sel_wr && reg_wdata[10:9] == 2'h3
      ##1 sel_rd |=> !reg_rdata[15])
      else $error("illegal word select started an access");
   a_post_cause: assert property (cfg_post_done |-> $past(dma_wr))
      else $error("post without a DMA update");
   a_small_only: assert property (cfg_policy == 2'h1 |-> cfg_use_small)
      else $error("small policy not using small buffers");
   a_large_only: assert property (cfg_policy == 2'h0 |-> !cfg_use_small)
      else $error("large policy using small buffers");
   a_reset_quiet: assert property ($fell(reset) |-> !cfg_enable && !cfg_post_done)
      else $error("outputs active after reset");
endmodule : rxcfg_chk
bind rxcfg_top rxcfg_chk rxcfg_chk_inst (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .dma_wr, .cfg_enable, .cfg_policy, .cfg_use_small, .cfg_post_done);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench: indirect register accesses and DMA entry updates.
// Assumes the design answers within a few cycles of each command.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb;
   import rxcfg_pkg::*;
   logic        sys_clk, reset, reg_wr, reg_rd, dma_wr, dma_first_buf, dma_pkt_done;
   logic        cfg_enable, cfg_use_small, cfg_post_done;
   logic [1:0]  cfg_policy;
   logic [2:0]  dma_buf_count, cfg_threshold;
   logic [7:0]  dma_channel;
   logic [11:0] reg_addr;
   logic [12:0] dma_byte_count;
   logic [15:0] reg_wdata, reg_rdata, rd_v, dma_cur_desc, dma_start_desc;
   logic [31:0] dma_buf_addr;
   logic [15:0] exp_w [6] = '{16'h5A5A, 16'hA5A5, 16'h1111, 16'h2222, 16'h8185, 16'h7FFC};
   int          errors = 0;
   int          compares = 0;
   rxcfg_top rxcfg_top_inst (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .dma_channel, .dma_wr, .dma_buf_addr, .dma_cur_desc, .dma_start_desc,
      .dma_first_buf, .dma_byte_count, .dma_buf_count, .dma_pkt_done, .cfg_enable,
      .cfg_policy, .cfg_use_small, .cfg_threshold, .cfg_post_done);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic end_of_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Command then an immediate select read, the only way to see busy high
   task automatic sel_cmd(input logic [15:0] d, input logic busy);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= RXCFG_SELECT_OFF; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0; reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata[15], busy)
   endtask : sel_cmd
   // Bounded so a stuck busy flag ends the run instead of hanging it
   task automatic poll;
      int n;
      n = 0;
      rd_v = 16'h8000;
      while (rd_v[15] !== 1'b0) begin
         rd(RXCFG_SELECT_OFF, rd_v);
         n++;
         if (n > 20) begin errors++; end_of_test; end
      end
   endtask : poll
   task automatic ind_wr(input logic [7:0] ch, input logic [15:0] d);
      wr(RXCFG_DATA_OFF, d);
      sel_cmd({5'h00, RXCFG_WS_HOST_WR, ch}, 1'b1);
      poll;
   endtask : ind_wr
   task automatic ind_rd(input logic [7:0] ch, input logic [2:0] ws, input logic [15:0] e);
      sel_cmd({5'h08, ws, ch}, 1'b1);
      poll;
      rd(RXCFG_DATA_OFF, rd_v);
      `CHK(rd_v, e)
   endtask : ind_rd
   task automatic dma_upd(input logic [2:0] bc, input logic done, input logic f, input int e);
      int n;
      n = 0;
      @(posedge sys_clk);
      dma_wr <= 1'b1; dma_buf_count <= bc; dma_pkt_done <= done; dma_first_buf <= f;
      @(posedge sys_clk);
      dma_wr <= 1'b0;
      repeat (4) begin #1 if (cfg_post_done === 1'b1) n++; @(posedge sys_clk); end
      `CHK(n, e)
   endtask : dma_upd
   initial begin
      {reg_wr, reg_rd, dma_wr, dma_first_buf, dma_pkt_done, dma_buf_count} = '0;
      {reg_addr, reg_wdata} = '0;
      reset = 1'b1;
      dma_channel = 8'h12;
      dma_buf_addr = 32'hA5A55A5A;
      dma_cur_desc = 16'h1111;
      dma_start_desc = 16'h2222;
      dma_byte_count = 13'h1FFF;  // Above the limit, so the clamp shows
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      rd(RXCFG_SELECT_OFF, rd_v);
      `CHK(rd_v, RXCFG_SELECT_RST)
      rd(12'h778, rd_v);
      `CHK(rd_v, 16'h0000)
      ind_wr(8'h00, 16'h0385);
      ind_wr(8'hFF, 16'h0083);
      ind_rd(8'h00, 3'h4, 16'h0385);
      ind_rd(8'hFF, 3'h4, 16'h0083);
      wr(RXCFG_DATA_OFF, 16'h1234);
      sel_cmd(16'h0000, 1'b1);
      poll;
      ind_rd(8'h00, 3'h0, 16'h0000);
      for (int w = 6; w < 8; w++) begin
         sel_cmd({5'h08, 3'(w), 8'h00}, 1'b0);
      end
      ind_wr(8'h12, 16'h0185);
      dma_upd(3'h3, 1'b0, 1'b1, 1);
      for (int i = 0; i < 6; i++) ind_rd(8'h12, 3'(i), exp_w[i]);
      `CHK(cfg_use_small, 1'b1)
      dma_upd(3'h2, 1'b0, 1'b0, 0);
      dma_upd(3'h0, 1'b1, 1'b0, 1);
      for (int t = 0; t < 8; t++) begin
         ind_wr(8'h12, {6'h00, 3'(t), 4'h0, 2'(t % 3), 1'(t != 3)});
         dma_upd(3'h4, 1'b0, 1'b0, (t != 0 && t <= 4 && t != 3) ? 1 : 0);
         `CHK(cfg_threshold, 3'(t))
         `CHK(cfg_policy, 2'(t % 3))
         `CHK(cfg_enable, 1'(t != 3))
         `CHK(cfg_use_small, 1'(t % 3 == 1))
      end
      // Outputs must follow the DMA's channel, one cycle late
      dma_channel <= 8'h00;
      @(posedge sys_clk);
      #1;
      `CHK(cfg_threshold, 3'h7)
      `CHK(cfg_policy, RXCFG_POL_MIXED)
      end_of_test;
   end
endmodule : tb
`default_nettype wire
